// >>> logic/pcs_pkg.sv
/*
  Package of the program counter sequencer: file addresses, field positions,
  reset values, cycle costs, the decoded operation kinds and the operation carrier.
  Assumes a core decoder that presents one decoded operation per instruction cycle.
*/
`default_nettype none

package pcs_pkg;

  // ****************************************************************
  // widths and addresses
  // ****************************************************************
  localparam int CNT_W_DEF = 12;
  localparam int STACK_DEPTH_DEF = 8;
  localparam logic [4:0] ADDR_COUNTER_LOW = 5'h02;
  localparam logic [4:0] ADDR_CORE_STATUS = 5'h03;
  localparam logic [4:0] ADDR_PORT_DATA = 5'h05;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int PAGE_LSB = 5;
  localparam int PAGE_MSB = 7;
  localparam logic [7:0] CORE_STATUS_RESET = 8'h00;
  localparam logic [7:0] PORT_DATA_RESET = 8'h00;
  localparam logic [11:0] IRQ_VECTOR = 12'h000;

  // ****************************************************************
  // timing, in instruction cycles unless noted
  // ****************************************************************
  localparam logic [1:0] CLKS_PER_ICYC_COMPAT_M1 = 2'h3;
  localparam logic [2:0] SKIP_CYC = 3'h2;
  localparam logic [2:0] JUMP_CYC_COMPAT = 3'h2;
  localparam logic [2:0] JUMP_CYC_TURBO = 3'h3;
  localparam logic [2:0] CNTW_CYC_COMPAT = 3'h4;
  localparam logic [2:0] CNTW_CYC_TURBO = 3'h3;
  localparam logic [2:0] IRQ_CYC = 3'h3;

  // ****************************************************************
  // decoded operations
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_PLAIN = 4'h0,
    OP_SKIP_IF_BIT_HIGH = 4'h1,
    OP_ABSOLUTE_JUMP = 4'h2,
    OP_SUBROUTINE_ENTRY = 4'h3,
    OP_PAGE = 4'h4,
    OP_MOVE = 4'h5,
    OP_ADD = 4'h6,
    OP_BIT_SET = 4'h7,
    OP_BIT_CLEAR = 4'h8
  } pcs_kind_t;

  typedef struct packed {
    pcs_kind_t kind;
    logic [8:0] target;
    logic [4:0] faddr;
    logic [2:0] bitsel;
    logic [7:0] operand;
  } pcs_op_t;

endpackage

`default_nettype wire

// >>> logic/pcs_return_stack.sv
/*
  Return-address stack of the sequencer: a shift stack with no pointer.
  Assumes the sequencer pushes at most once per clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_return_stack import pcs_pkg::*; #(
  parameter int W = CNT_W_DEF,
  parameter int DEPTH = STACK_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [W-1:0] push_data,
  output logic [W-1:0] top
);

  logic [W-1:0] level_r [DEPTH];

  // ****************************************************************
  // push shifts every level down, the bottom word falls out
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        level_r[i] <= '0;
      end
    end else if (push) begin
      level_r[0] <= push_data;
      for (int i = 1; i < DEPTH; i++) begin
        level_r[i] <= level_r[i-1];
      end
    end
  end

  assign top = level_r[0];

endmodule

`default_nettype wire

// >>> logic/pcs_sequencer.sv
/*
  Program flow sequencer: program counter, page select, low counter file register,
  one port data register, cycle costs of flow changes, and the return stack.
  Assumes the core decoder holds OP steady until OP_READY and that TURBO_MODE is static.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_sequencer import pcs_pkg::*; #(
  parameter int CNT_W = CNT_W_DEF,
  parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic TURBO_MODE,
  input wire logic IRQ_REQ,
  input wire pcs_op_t OP,
  output logic OP_READY,
  output logic [CNT_W-1:0] FETCH_ADDR,
  output logic PIPE_FLUSH,
  output logic [CNT_W-1:0] STACK_TOP,
  input wire logic [4:0] FILE_RADDR,
  output logic [7:0] FILE_RDATA,
  output logic [7:0] PORT_DRIVE,
  input wire logic [7:0] PORT_PINS
);

  localparam logic [CNT_W-1:0] CNT_RESET = '1;

  logic turbo_s1_r;
  logic turbo_r;
  logic [7:0] pins_s1_r;
  logic [7:0] pins_r;
  logic [1:0] div_r;
  logic tick;
  logic [2:0] busy_r;
  logic [2:0] busy_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] cnt_plus1;
  logic [7:0] core_status_page_select_r;
  logic [7:0] port_data_r;
  logic [7:0] file_rdata_r;
  logic flush_r;
  logic accept;
  logic take_irq;
  logic exec;
  logic [7:0] cur;
  logic [7:0] mask;
  logic [7:0] wr_data;
  logic wr_en;
  logic cnt_wr;
  logic skip_hit;
  logic push;
  logic [2:0] page;

  function automatic logic [7:0] file_val(input logic [4:0] a, input logic [7:0] low,
                                          input logic [7:0] stat, input logic [7:0] pins);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_COUNTER_LOW: v = low;
      ADDR_CORE_STATUS: v = stat;
      ADDR_PORT_DATA: v = pins;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // synchronisers for mode and pins
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      turbo_s1_r <= 1'b0;
      turbo_r <= 1'b0;
      pins_s1_r <= 8'h00;
      pins_r <= 8'h00;
    end else begin
      turbo_s1_r <= TURBO_MODE;
      turbo_r <= turbo_s1_r;
      pins_s1_r <= PORT_PINS;
      pins_r <= pins_s1_r;
    end
  end

  // ****************************************************************
  // instruction cycle timing
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_r <= 2'h0;
    end else if (turbo_r) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  assign tick = turbo_r || (div_r == CLKS_PER_ICYC_COMPAT_M1);
  assign OP_READY = tick && (busy_r == 3'h0);
  assign accept = OP_READY;
  assign take_irq = accept && IRQ_REQ;
  assign exec = accept && !IRQ_REQ;

  // ****************************************************************
  // operand fetch and modify
  // ****************************************************************
  assign cnt_plus1 = cnt_r + CNT_W'(1);
  assign page = core_status_page_select_r[PAGE_MSB:PAGE_LSB];
  assign cur = file_val(OP.faddr, cnt_plus1[7:0], core_status_page_select_r, pins_r);
  assign mask = 8'h01 << OP.bitsel;
  assign skip_hit = exec && (OP.kind == OP_SKIP_IF_BIT_HIGH) && cur[OP.bitsel];
  assign push = exec && (OP.kind == OP_SUBROUTINE_ENTRY);

  always_comb begin
    wr_en = exec;
    case (OP.kind)
      OP_MOVE: wr_data = OP.operand;
      OP_ADD: wr_data = cur + OP.operand;
      OP_BIT_SET: wr_data = cur | mask;
      OP_BIT_CLEAR: wr_data = cur & ~mask;
      default: begin
        wr_data = cur;
        wr_en = 1'b0;
      end
    endcase
  end

  assign cnt_wr = wr_en && (OP.faddr == ADDR_COUNTER_LOW);

  // ****************************************************************
  // next counter value and stall cost
  // ****************************************************************
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = 3'h0;
    if (take_irq) begin
      cnt_nxt = CNT_W'(IRQ_VECTOR);
      busy_nxt = IRQ_CYC - 3'h1;
    end else if (exec) begin
      case (OP.kind)
        OP_ABSOLUTE_JUMP: begin
          cnt_nxt = CNT_W'({page, OP.target});
          busy_nxt = (turbo_r ? JUMP_CYC_TURBO : JUMP_CYC_COMPAT) - 3'h1;
        end
        OP_SUBROUTINE_ENTRY: begin
          cnt_nxt = CNT_W'({page, 1'b0, OP.target[7:0]});
          busy_nxt = (turbo_r ? JUMP_CYC_TURBO : JUMP_CYC_COMPAT) - 3'h1;
        end
        OP_SKIP_IF_BIT_HIGH: begin
          if (skip_hit) begin
            cnt_nxt = cnt_r + CNT_W'(2);
            busy_nxt = SKIP_CYC - 3'h1;
          end else begin
            cnt_nxt = cnt_plus1;
          end
        end
        default: begin
          if (cnt_wr) begin
            cnt_nxt = {cnt_r[CNT_W-1:8], wr_data};
            busy_nxt = (turbo_r ? CNTW_CYC_TURBO : CNTW_CYC_COMPAT) - 3'h1;
          end else begin
            cnt_nxt = cnt_plus1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_r <= CNT_RESET;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // cancelled instructions occupy the slots counted here
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      busy_r <= 3'h0;
      flush_r <= 1'b0;
    end else begin
      flush_r <= accept && (busy_nxt != 3'h0);
      if (accept) begin
        busy_r <= busy_nxt;
      end else if (tick && (busy_r != 3'h0)) begin
        busy_r <= busy_r - 3'h1;
      end
    end
  end

  // ****************************************************************
  // file registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      core_status_page_select_r <= CORE_STATUS_RESET;
    end else if (exec && (OP.kind == OP_PAGE)) begin
      core_status_page_select_r[PAGE_MSB:PAGE_LSB] <= OP.operand[2:0];
    end else if (wr_en && (OP.faddr == ADDR_CORE_STATUS)) begin
      core_status_page_select_r <= wr_data;
    end
  end

  // software keeps a spacer between port read-modify-writes, pins lag the write
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      port_data_r <= PORT_DATA_RESET;
    end else if (wr_en && (OP.faddr == ADDR_PORT_DATA)) begin
      port_data_r <= wr_data;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      file_rdata_r <= 8'h00;
    end else begin
      file_rdata_r <= file_val(FILE_RADDR, cnt_plus1[7:0], core_status_page_select_r, pins_r);
    end
  end

  // ****************************************************************
  // return stack
  // ****************************************************************
  pcs_return_stack #(
    .W(CNT_W),
    .DEPTH(STACK_DEPTH)
  ) u_stack (
    .clk(CLK),
    .resetn(RESETN),
    .push(push),
    .push_data(cnt_plus1),
    .top(STACK_TOP)
  );

  assign FETCH_ADDR = cnt_r;
  assign PIPE_FLUSH = flush_r;
  assign FILE_RDATA = file_rdata_r;
  assign PORT_DRIVE = port_data_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_reset_top: assert property (@(posedge CLK) disable iff (!RESETN)
    !$past(RESETN) |-> (FETCH_ADDR == CNT_RESET))
    else $error("counter not at top address after reset");

  chk_seq_step: assert property (@(posedge CLK) disable iff (!RESETN)
    (exec && (OP.kind == OP_PLAIN)) |=> (FETCH_ADDR == $past(cnt_r) + CNT_W'(1)))
    else $error("counter did not advance by one");

  chk_irq_vector: assert property (@(posedge CLK) disable iff (!RESETN)
    take_irq |=> (FETCH_ADDR == CNT_W'(IRQ_VECTOR)) && !OP_READY)
    else $error("interrupt did not vector to bottom");

  chk_skip_two: assert property (@(posedge CLK) disable iff (!RESETN)
    skip_hit |=> (FETCH_ADDR == $past(cnt_r) + CNT_W'(2)) && !OP_READY)
    else $error("skip did not add two and stall");

  chk_jump_target: assert property (@(posedge CLK) disable iff (!RESETN)
    (exec && (OP.kind == OP_ABSOLUTE_JUMP))
      |=> (FETCH_ADDR == CNT_W'({$past(page), $past(OP.target)})))
    else $error("jump target wrong");

  chk_call_target: assert property (@(posedge CLK) disable iff (!RESETN)
    push |=> (FETCH_ADDR == CNT_W'({$past(page), 1'b0, $past(OP.target[7:0])}))
      && (STACK_TOP == $past(cnt_r) + CNT_W'(1)))
    else $error("subroutine entry target or return address wrong");

  chk_page_only: assert property (@(posedge CLK) disable iff (!RESETN)
    (exec && (OP.kind == OP_PAGE)) |=> (page == $past(OP.operand[2:0]))
      && (core_status_page_select_r[4:0] == $past(core_status_page_select_r[4:0])))
    else $error("page operation disturbed other bits");

  chk_low_write: assert property (@(posedge CLK) disable iff (!RESETN)
    cnt_wr |=> (FETCH_ADDR[CNT_W-1:8] == $past(cnt_r[CNT_W-1:8]))
      && (FETCH_ADDR[7:0] == $past(wr_data)) && PIPE_FLUSH)
    else $error("low counter write reached upper bits");

  chk_jump_turbo: assert property (@(posedge CLK) disable iff (!RESETN)
    (turbo_r && exec && (OP.kind == OP_ABSOLUTE_JUMP)) |=> (!OP_READY)[*2] ##1 OP_READY)
    else $error("turbo jump cost not three cycles");

  chk_low_compat: assert property (@(posedge CLK) disable iff (!RESETN)
    (!turbo_r && $stable(turbo_r) && cnt_wr) |=> (!OP_READY)[*8] ##8 OP_READY)
    else $error("compatible low counter jump cost not four cycles");

endmodule

`default_nettype wire

// >>> verification/pcs_prog_mem.sv
/*
  Program memory model facing the sequencer: returns the decoded operation
  stored at the current fetch address, a short delay after each rising clock edge.
  Assumes the bench fills mem before releasing reset; unwritten words are plain.
*/
`timescale 1ns/1ps
`default_nettype none

module pcs_prog_mem import pcs_pkg::*; (
  input wire logic clk,
  input wire logic [11:0] fetch_addr,
  output var pcs_op_t op
);
  pcs_op_t mem [0:4095];

  // ****************************************************************
  // storage and fetch
  // ****************************************************************
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = '0;
    end
    op = '0;
  end

  // the word follows the address only after the edge has updated it,
  // so an operation stays put until the sequencer takes it
  always @(posedge clk) begin
    #1;
    op = mem[fetch_addr];
  end
endmodule

`default_nettype wire

// >>> verification/tb.sv
/*
  Self-checking bench of the program counter sequencer: runs one program in
  turbo and in compatible mode, predicts every flow change and cycle cost.
  Assumes the program memory model and the sequencer with a 12-bit counter.
*/
`timescale 1ns/1ps
`default_nettype none

module tb import pcs_pkg::*; ;
  typedef struct {
    logic [11:0] addr;
    int gap;
    logic flush;
    logic [11:0] stk;
    logic [7:0] port;
  } pcs_note_t;

  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic TURBO_MODE = 1'b1;
  logic IRQ_REQ = 1'b0;
  logic [4:0] FILE_RADDR = 5'h00;
  logic [7:0] PORT_PINS = 8'h00;
  wire pcs_op_t op_bus;
  wire logic OP_READY;
  wire logic [11:0] FETCH_ADDR;
  wire logic PIPE_FLUSH;
  wire logic [11:0] STACK_TOP;
  wire logic [7:0] FILE_RDATA;
  wire logic [7:0] PORT_DRIVE;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int cnt = 0;
  int g = 0;
  bit took = 0;
  bit turbo;
  logic [11:0] m_pc;
  logic [11:0] m_stk;
  logic [7:0] m_stat;
  logic [7:0] m_port;
  pcs_note_t notes[$];
  pcs_note_t nt;

  always #12.5 CLK = ~CLK;

  pcs_sequencer #(.CNT_W(12), .STACK_DEPTH(8)) u_dut (.CLK(CLK), .RESETN(RESETN),
    .TURBO_MODE(TURBO_MODE), .IRQ_REQ(IRQ_REQ), .OP(op_bus), .OP_READY(OP_READY),
    .FETCH_ADDR(FETCH_ADDR), .PIPE_FLUSH(PIPE_FLUSH), .STACK_TOP(STACK_TOP),
    .FILE_RADDR(FILE_RADDR), .FILE_RDATA(FILE_RDATA), .PORT_DRIVE(PORT_DRIVE),
    .PORT_PINS(PORT_PINS));

  pcs_prog_mem u_mem (.clk(CLK), .fetch_addr(FETCH_ADDR), .op(op_bus));

  // ****************************************************************
  // reporting
  // ****************************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check_w(input string what, input logic [11:0] exp, input logic [11:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_b(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_n(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      mismatches++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ****************************************************************
  // reference model of one taken operation
  // ****************************************************************
  function automatic logic [7:0] fread(input logic [4:0] a);
    case (a)
      ADDR_COUNTER_LOW: fread = m_pc[7:0] + 8'h01;
      ADDR_CORE_STATUS: fread = m_stat;
      ADDR_PORT_DATA: fread = PORT_PINS;
      default: fread = 8'h00;
    endcase
  endfunction

  task automatic step_model(input pcs_op_t op, input bit irq, output int c);
    logic [11:0] nxt;
    logic [7:0] v;
    nxt = m_pc + 12'h001;
    c = 1;
    v = fread(op.faddr);
    if (irq) begin
      nxt = IRQ_VECTOR;
      c = 3;
    end else begin
      case (op.kind)
        OP_SKIP_IF_BIT_HIGH: if (v[op.bitsel]) begin
          nxt = m_pc + 12'h002;
          c = 2;
        end
        OP_ABSOLUTE_JUMP: begin
          nxt = {m_stat[7:5], op.target};
          c = turbo ? 3 : 2;
        end
        OP_SUBROUTINE_ENTRY: begin
          m_stk = nxt;
          nxt = {m_stat[7:5], 1'b0, op.target[7:0]};
          c = turbo ? 3 : 2;
        end
        OP_PAGE: m_stat[7:5] = op.operand[2:0];
        OP_MOVE, OP_ADD, OP_BIT_SET, OP_BIT_CLEAR: begin
          if (op.kind == OP_MOVE) v = op.operand;
          if (op.kind == OP_ADD) v = v + op.operand;
          if (op.kind == OP_BIT_SET) v = v | (8'h01 << op.bitsel);
          if (op.kind == OP_BIT_CLEAR) v = v & ~(8'h01 << op.bitsel);
          if (op.faddr == ADDR_COUNTER_LOW) begin
            nxt = {m_pc[11:8], v};
            c = turbo ? 3 : 4;
          end
          if (op.faddr == ADDR_CORE_STATUS) m_stat = v;
          if (op.faddr == ADDR_PORT_DATA) m_port = v;
        end
        default: ;
      endcase
    end
    m_pc = nxt;
  endtask

  // ****************************************************************
  // watcher: one note per taken operation
  // ****************************************************************
  always @(negedge CLK) begin
    if (!RESETN) begin
      took = 0;
      cnt = 0;
    end else begin
      if (took && notes.size() > 0) begin
        nt = notes.pop_front();
        check_w("fetch address", nt.addr, FETCH_ADDR);
        check_w("stack top", nt.stk, STACK_TOP);
        check_b("flush", {7'h00, nt.flush}, {7'h00, PIPE_FLUSH});
        check_b("port drive", nt.port, PORT_DRIVE);
        if (nt.gap != 0) check_n("op spacing", nt.gap, g);
      end
      cnt++;
      took = (OP_READY === 1'b1);
      if (took) begin
        g = cnt;
        cnt = 0;
      end
    end
  end

  // ****************************************************************
  // driver
  // ****************************************************************
  task automatic put(input logic [11:0] a, input pcs_kind_t k, input logic [8:0] t,
                     input logic [4:0] f, input logic [2:0] b, input logic [7:0] v);
    u_mem.mem[a] = '{k, t, f, b, v};
  endtask

  task automatic run_mode(input bit mode);
    pcs_op_t op;
    int c;
    int prev_c;
    int gap;
    bit irq;
    TURBO_MODE = mode;
    turbo = mode;
    RESETN = 1'b0;
    repeat (10) @(posedge CLK);
    #1;
    check_w("reset address", 12'hFFF, FETCH_ADDR);
    m_pc = 12'hFFF;
    m_stat = CORE_STATUS_RESET;
    m_port = PORT_DATA_RESET;
    m_stk = 12'h000;
    RESETN = 1'b1;
    prev_c = 0;
    for (int s = 0; s < 15; s++) begin
      irq = (s == 12);
      op = u_mem.mem[m_pc];
      IRQ_REQ = irq;
      do @(negedge CLK); while (OP_READY !== 1'b1);
      step_model(op, irq, c);
      // spacing per flow change in clocks
      gap = (s < 2) ? 0 : prev_c;
      notes.push_back(pcs_note_t'{m_pc, gap, c > 1, m_stk, m_port});
      prev_c = turbo ? c : 4 * c;
      @(posedge CLK);
      #1;
    end
    repeat (2) @(negedge CLK);
    check_n("notes left", 0, notes.size());
    $display("test %s done", mode ? "turbo program" : "compatible program");
    // the next reset or read starts just after a rising edge
    @(posedge CLK);
    #1;
  endtask

  task automatic file_read(input logic [4:0] a, input logic [7:0] exp);
    FILE_RADDR = a;
    @(posedge CLK);
    #1;
    check_b("file read", exp, FILE_RDATA);
  endtask

  initial begin
    logic [7:0] rnd;
    logic [2:0] bsel;
    // let the memory model clear its words before the program is loaded
    #1;
    void'($urandom(32'h8c95b789));
    rnd = 8'($urandom);
    bsel = 3'($urandom_range(7, 0));
    PORT_PINS = 8'($urandom);
    put(12'hFFF, OP_PAGE, 9'h000, 5'h00, 3'h0, 8'h03);
    put(12'h000, OP_BIT_SET, 9'h000, ADDR_CORE_STATUS, 3'h0, 8'h00);
    put(12'h001, OP_SKIP_IF_BIT_HIGH, 9'h000, ADDR_CORE_STATUS, 3'h0, 8'h00);
    put(12'h003, OP_SKIP_IF_BIT_HIGH, 9'h000, ADDR_CORE_STATUS, 3'h1, 8'h00);
    put(12'h004, OP_BIT_CLEAR, 9'h000, ADDR_CORE_STATUS, 3'h0, 8'h00);
    put(12'h005, OP_ABSOLUTE_JUMP, 9'h1E0, 5'h00, 3'h0, 8'h00);
    put(12'h7E0, OP_SUBROUTINE_ENTRY, 9'h040, 5'h00, 3'h0, 8'h00);
    put(12'h640, OP_MOVE, 9'h000, ADDR_COUNTER_LOW, 3'h0, 8'h10);
    put(12'h610, OP_ADD, 9'h000, ADDR_COUNTER_LOW, 3'h0, 8'h04);
    put(12'h615, OP_MOVE, 9'h000, ADDR_PORT_DATA, 3'h0, rnd);
    // a plain word at 616 spaces the two port updates
    put(12'h617, OP_BIT_SET, 9'h000, ADDR_PORT_DATA, bsel, 8'h00);
    run_mode(1'b1);
    run_mode(1'b0);
    do @(negedge CLK); while (OP_READY !== 1'b1);
    @(posedge CLK);
    #1;
    file_read(ADDR_COUNTER_LOW, FETCH_ADDR[7:0] + 8'h01);
    file_read(ADDR_CORE_STATUS, m_stat);
    file_read(ADDR_PORT_DATA, PORT_PINS);
    file_read(5'h1F, 8'h00);
    $display("test file reads done");
    print_verdict();
  end
endmodule

`default_nettype wire
